//--- core/mie_core.sv
// Instruction execution core of a small 8-bit controller with an APB register port
`timescale 1ns/100ps
`include "mie_defines.svh"

module mie_core import mie_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             core_active
);

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	logic [15:0]    prog_mem [`MIE_PROG_WORDS];
	logic [7:0]     dmem [`MIE_DMEM_WORDS];
	logic [7:0]     stack_mem [`MIE_STACK_DEPTH];

	logic           run_q;
	logic           gie_q;
	logic           halted_q;
	logic [1:0]     phase_q;
	logic [7:0]     pc_q;
	logic [15:0]    ir_q;
	logic           flush_q;
	logic [7:0]     acc_q;
	logic           z_q;
	logic           c_q;
	logic [2:0]     sp_q;
	logic [7:0]     prog_addr_q;
	logic [5:0]     dmem_addr_q;
	logic [31:0]    icount_q;
	logic [31:0]    prdata_q;
	logic           pready_q;
	logic           pslverr_q;
	logic           active_q;

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------
	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction

	function automatic logic zero8(input logic [7:0] v);
		zero8 = (v == 8'h00);
	endfunction

	// ------------------------------------------------------------------------
	// Decode and execute
	// ------------------------------------------------------------------------
	mie_instr_type  ins;
	logic           icycle_end;
	logic [7:0]     mval;
	logic [7:0]     opnd;
	logic [8:0]     wide;
	logic [7:0]     res;
	logic           res_c;
	logic           wr_acc;
	logic           wr_mem;
	logic           upd_z;
	logic           upd_c;
	logic           do_jump;
	logic [7:0]     jump_tgt;
	logic           do_skip;
	logic           do_push;
	logic           do_pop;
	logic           do_tab;
	logic           set_gie;
	logic           do_halt;
	logic           apb_wr;
	logic [31:0]    rd_data;
	logic           rd_ok;
	mie_status_type stat;

	assign ins        = mie_instr_type'(ir_q);
	assign icycle_end = ce && run_q && !halted_q && (phase_q == `MIE_PHASE_LAST);
	assign mval       = (ins.arg == `MIE_ADDR_PCL) ? 8'(pc_q - 8'h01) : dmem[ins.arg[5:0]];

	always_comb begin
		opnd     = mval;
		wide     = 9'h000;
		res      = acc_q;
		res_c    = c_q;
		wr_acc   = 1'b0;
		wr_mem   = 1'b0;
		upd_z    = 1'b0;
		upd_c    = 1'b0;
		do_jump  = 1'b0;
		jump_tgt = ins.arg;
		do_skip  = 1'b0;
		do_push  = 1'b0;
		do_pop   = 1'b0;
		do_tab   = 1'b0;
		set_gie  = 1'b0;
		do_halt  = 1'b0;
		if (ins.op == OP_ADD_I || ins.op == OP_SUB_I || ins.op == OP_MOV_I2A ||
		    ins.op == OP_AND_I || ins.op == OP_OR_I || ins.op == OP_XOR_I) begin
			opnd = ins.arg;
		end
		case (ins.op)
			OP_MOV_M2A, OP_MOV_I2A: begin
				res    = opnd;
				wr_acc = 1'b1;
			end
			OP_MOV_A2M: begin
				res    = acc_q;
				wr_mem = 1'b1;
			end
			OP_ADD_M, OP_ADD_I: begin
				wide   = {1'b0, acc_q} + {1'b0, opnd};
				res    = wide[7:0];
				res_c  = wide[8];
				wr_acc = 1'b1;
				upd_z  = 1'b1;
				upd_c  = 1'b1;
			end
			OP_SUB_M, OP_SUB_I: begin
				wide   = {1'b0, acc_q} - {1'b0, opnd};
				res    = wide[7:0];
				res_c  = wide[8];
				wr_acc = 1'b1;
				upd_z  = 1'b1;
				upd_c  = 1'b1;
			end
			OP_INC, OP_DEC: begin
				res    = (ins.op == OP_INC) ? 8'(mval + 8'h01) : 8'(mval - 8'h01);
				wr_mem = ins.sel[0];
				wr_acc = !ins.sel[0];
				upd_z  = 1'b1;
			end
			OP_AND_M, OP_AND_I: begin
				res    = acc_q & opnd;
				wr_acc = 1'b1;
				upd_z  = 1'b1;
			end
			OP_OR_M, OP_OR_I: begin
				res    = acc_q | opnd;
				wr_acc = 1'b1;
				upd_z  = 1'b1;
			end
			OP_XOR_M, OP_XOR_I: begin
				res    = acc_q ^ opnd;
				wr_acc = 1'b1;
				upd_z  = 1'b1;
			end
			OP_CPL: begin
				res    = ~mval;
				wr_mem = ins.sel[0];
				wr_acc = !ins.sel[0];
				upd_z  = 1'b1;
			end
			OP_RR, OP_RL: begin
				res    = (ins.op == OP_RR) ? {mval[0], mval[7:1]} : {mval[6:0], mval[7]};
				wr_mem = ins.sel[0];
				wr_acc = !ins.sel[0];
			end
			OP_RRC, OP_RLC: begin
				res    = (ins.op == OP_RRC) ? {c_q, mval[7:1]} : {mval[6:0], c_q};
				res_c  = (ins.op == OP_RRC) ? mval[0] : mval[7];
				wr_mem = ins.sel[0];
				wr_acc = !ins.sel[0];
				upd_c  = 1'b1;
			end
			OP_JUMP: begin
				do_jump = 1'b1;
			end
			OP_CALL: begin
				do_jump = 1'b1;
				do_push = 1'b1;
			end
			OP_RETURN: begin
				do_pop = 1'b1;
			end
			OP_IRETURN: begin
				do_pop  = 1'b1;
				set_gie = 1'b1;
			end
			OP_TABRD: begin
				do_tab = 1'b1;
			end
			OP_SKIP_Z: begin
				do_skip = zero8(mval);
			end
			OP_SKIP_BIT0: begin
				do_skip = zero8(mval & bit_mask(ins.sel));
			end
			OP_SKIP_BIT1: begin
				do_skip = !zero8(mval & bit_mask(ins.sel));
			end
			OP_BIT_SET: begin
				res    = mval | bit_mask(ins.sel);
				wr_mem = 1'b1;
			end
			OP_BIT_CLEAR: begin
				res    = mval & ~bit_mask(ins.sel);
				wr_mem = 1'b1;
			end
			OP_HALT: begin
				do_halt = 1'b1;
			end
			default: begin
				res = acc_q;
			end
		endcase
		// write to low PC byte jumps
		if (wr_mem && ins.arg == `MIE_ADDR_PCL) begin
			do_jump  = 1'b1;
			jump_tgt = res;
		end
	end

	// ------------------------------------------------------------------------
	// Instruction cycle sequencing
	// ------------------------------------------------------------------------
	// four clocks per cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q <= 2'h0;
		end else if (ce) begin
			if (!run_q || halted_q) begin
				phase_q <= 2'h0;
			end else begin
				phase_q <= 2'(phase_q + 2'h1);
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pc_q    <= `MIE_RESET_PC;
			ir_q    <= `MIE_NOP_WORD;
			flush_q <= 1'b1;
			sp_q    <= 3'h0;
		end else if (ce) begin
			if (apb_wr && paddr == `MIE_OFS_CTRL && pwdata[`MIE_CTRL_RESTART]) begin
				pc_q    <= `MIE_RESET_PC;
				ir_q    <= `MIE_NOP_WORD;
				flush_q <= 1'b1;
				sp_q    <= 3'h0;
			end else if (icycle_end) begin
				if (flush_q) begin
					ir_q    <= prog_mem[pc_q];
					pc_q    <= 8'(pc_q + 8'h01);
					flush_q <= 1'b0;
				end else if (do_jump) begin
					pc_q    <= jump_tgt;
					ir_q    <= `MIE_NOP_WORD;
					flush_q <= 1'b1;
					if (do_push) begin
						sp_q <= 3'(sp_q + 3'h1);
					end
				end else if (do_pop) begin
					pc_q    <= stack_mem[3'(sp_q - 3'h1)];
					sp_q    <= 3'(sp_q - 3'h1);
					ir_q    <= `MIE_NOP_WORD;
					flush_q <= 1'b1;
				end else if (do_skip) begin
					pc_q    <= 8'(pc_q + 8'h01);
					ir_q    <= `MIE_NOP_WORD;
					flush_q <= 1'b1;
				end else if (do_tab) begin
					ir_q    <= `MIE_NOP_WORD;
					flush_q <= 1'b1;
				end else begin
					ir_q <= prog_mem[pc_q];
					pc_q <= 8'(pc_q + 8'h01);
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (ce && icycle_end && !flush_q && do_push) begin
			stack_mem[sp_q] <= pc_q;
		end
	end

	// ------------------------------------------------------------------------
	// Accumulator and flags
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q <= `MIE_RESET_BYTE;
			z_q   <= 1'b0;
			c_q   <= 1'b0;
		end else if (ce && icycle_end && !flush_q) begin
			if (do_tab) begin
				acc_q <= prog_mem[mval][7:0];
			end else if (wr_acc) begin
				acc_q <= res;
			end
			if (upd_z) begin
				z_q <= zero8(res);
			end
			if (upd_c) begin
				c_q <= res_c;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Memories: the core write wins over a bus write in the same cycle
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (ce) begin
			if (icycle_end && !flush_q && wr_mem && ins.arg != `MIE_ADDR_PCL) begin
				dmem[ins.arg[5:0]] <= res;
			end else if (apb_wr && paddr == `MIE_OFS_DMEM_DATA) begin
				dmem[dmem_addr_q] <= pwdata[7:0];
			end
			if (apb_wr && paddr == `MIE_OFS_PROG_DATA) begin
				prog_mem[prog_addr_q] <= pwdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Control state: hardware set wins over software clear
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			run_q    <= 1'b0;
			gie_q    <= 1'b0;
			halted_q <= 1'b0;
			icount_q <= 32'h0000_0000;
		end else if (ce) begin
			if (apb_wr && paddr == `MIE_OFS_CTRL) begin
				run_q <= pwdata[`MIE_CTRL_RUN];
			end
			if (icycle_end && !flush_q && set_gie) begin
				gie_q <= 1'b1;
			end else if (apb_wr && paddr == `MIE_OFS_CTRL) begin
				gie_q <= pwdata[`MIE_CTRL_GIE];
			end
			if (icycle_end && !flush_q && do_halt) begin
				halted_q <= 1'b1;
			end else if (apb_wr && paddr == `MIE_OFS_CTRL) begin
				halted_q <= 1'b0;
			end
			if (icycle_end) begin
				icount_q <= 32'(icount_q + 32'h1);
			end
		end
	end

	// ------------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------------
	assign apb_wr = psel && penable && pready_q && pwrite && !pslverr_q;
	assign stat   = '{halted: halted_q, gie: gie_q, c: c_q, z: z_q, acc: acc_q, pc: pc_q};

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok   = 1'b1;
		if (paddr == `MIE_OFS_CTRL) begin
			rd_data = {30'h0, gie_q, run_q};
		end else if (paddr == `MIE_OFS_STATUS) begin
			rd_data = {12'h000, stat};
		end else if (paddr == `MIE_OFS_PROG_ADDR) begin
			rd_data = {24'h00_0000, prog_addr_q};
		end else if (paddr == `MIE_OFS_PROG_DATA) begin
			rd_data = {16'h0000, prog_mem[prog_addr_q]};
		end else if (paddr == `MIE_OFS_DMEM_ADDR) begin
			rd_data = {26'h000_0000, dmem_addr_q};
		end else if (paddr == `MIE_OFS_DMEM_DATA) begin
			rd_data = {24'h00_0000, dmem[dmem_addr_q]};
		end else if (paddr == `MIE_OFS_ICOUNT) begin
			rd_data = icount_q;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (ce) begin
			pready_q <= psel && !penable;
			if (psel && !penable) begin
				pslverr_q <= !rd_ok;
				prdata_q  <= (pwrite || !rd_ok) ? 32'h0000_0000 : rd_data;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// Address registers auto-increment after each data access
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prog_addr_q <= 8'h00;
			dmem_addr_q <= 6'h00;
		end else if (ce && psel && penable && pready_q && !pslverr_q) begin
			if (pwrite && paddr == `MIE_OFS_PROG_ADDR) begin
				prog_addr_q <= pwdata[7:0];
			end else if (paddr == `MIE_OFS_PROG_DATA) begin
				prog_addr_q <= 8'(prog_addr_q + 8'h01);
			end
			if (pwrite && paddr == `MIE_OFS_DMEM_ADDR) begin
				dmem_addr_q <= pwdata[5:0];
			end else if (paddr == `MIE_OFS_DMEM_DATA) begin
				dmem_addr_q <= 6'(dmem_addr_q + 6'h01);
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			active_q <= 1'b0;
		end else if (ce) begin
			active_q <= run_q && !halted_q;
		end
	end

	assign prdata      = prdata_q;
	assign pready      = pready_q;
	assign pslverr     = pslverr_q;
	assign core_active = active_q;

endmodule

//--- core/mie_defines.svh
// Offsets, field positions, reset values and timing counts of the execution core
`ifndef MIE_DEFINES_SVH
`define MIE_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MIE_CLKS_PER_ICYCLE   4
`define MIE_PHASE_LAST        2'h3

// ----------------------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------------------
`define MIE_OFS_CTRL          8'h00
`define MIE_OFS_STATUS        8'h04
`define MIE_OFS_PROG_ADDR     8'h08
`define MIE_OFS_PROG_DATA     8'h0C
`define MIE_OFS_DMEM_ADDR     8'h10
`define MIE_OFS_DMEM_DATA     8'h14
`define MIE_OFS_ICOUNT        8'h18

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define MIE_CTRL_RUN          0
`define MIE_CTRL_GIE          1
`define MIE_CTRL_RESTART      2

// ----------------------------------------------------------------------------
// Data memory map and sizes
// ----------------------------------------------------------------------------
`define MIE_ADDR_PCL          8'h02
`define MIE_DMEM_WORDS        64
`define MIE_PROG_WORDS        256
`define MIE_STACK_DEPTH       8
`define MIE_RESET_PC          8'h00
`define MIE_RESET_BYTE        8'h00
`define MIE_NOP_WORD          16'h0000

`endif

//--- core/mie_pkg.sv
// Types shared by the execution core
package mie_pkg;

	// ------------------------------------------------------------------------
	// Operations, encoded by their order in bits 15:11
	// ------------------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NOP, OP_MOV_M2A, OP_MOV_A2M, OP_MOV_I2A,
		OP_ADD_M, OP_ADD_I, OP_SUB_M, OP_SUB_I,
		OP_INC, OP_DEC, OP_AND_M, OP_OR_M,
		OP_XOR_M, OP_AND_I, OP_OR_I, OP_XOR_I,
		OP_CPL, OP_RR, OP_RL, OP_RRC,
		OP_RLC, OP_JUMP, OP_CALL, OP_RETURN,
		OP_IRETURN, OP_TABRD, OP_SKIP_Z, OP_SKIP_BIT0,
		OP_SKIP_BIT1, OP_BIT_SET, OP_BIT_CLEAR, OP_HALT
	} mie_op_type;

	// sel[0] picks memory (1) or accumulator (0) as destination; bit ops use sel as bit index
	typedef struct packed {
		mie_op_type op;
		logic [2:0] sel;
		logic [7:0] arg;
	} mie_instr_type;

	typedef struct packed {
		logic       halted;
		logic       gie;
		logic       c;
		logic       z;
		logic [7:0] acc;
		logic [7:0] pc;
	} mie_status_type;

endpackage

//--- verification/mie_core_props.sv
// Port-level checker for the execution core
`timescale 1ns/100ps
`include "mie_defines.svh"

module mie_core_props (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        core_active
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------------------
	// Helper: cycles since the last control write
	// ------------------------------------------------------------------------
	logic [1:0] since_q;
	logic       ctrl_wr;
	logic       mapped;

	assign ctrl_wr = ce && pready && pwrite && (paddr == `MIE_OFS_CTRL);
	assign mapped  = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			since_q <= 2'h3;
		end else if (ctrl_wr) begin
			since_q <= 2'h0;
		end else if (since_q != 2'h3) begin
			since_q <= since_q + 2'h1;
		end
	end

	// ------------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------------
	property p_ready_after_setup;
		ce && psel && !penable |=> pready;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready missing after setup");

	property p_ready_single;
		pready && ce |=> !pready;
	endproperty
	a_ready_single: assert property (p_ready_single) else $error("pready held over one cycle");

	property p_ready_in_access;
		pready |-> psel && penable;
	endproperty
	a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access phase");

	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

	property p_err_unmapped;
		pready && !mapped |-> pslverr && (prdata == 32'h0);
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

	property p_no_err_mapped;
		pready && mapped |-> !pslverr;
	endproperty
	a_no_err_mapped: assert property (p_no_err_mapped) else $error("mapped access refused");

	property p_active_cause;
		$rose(core_active) |-> since_q <= 2'h2;
	endproperty
	a_active_cause: assert property (p_active_cause) else $error("core started without control write");

	property p_rdata_stable;
		!(ce && psel && !penable) |=> $stable(prdata);
	endproperty
	a_rdata_stable: assert property (p_rdata_stable) else $error("prdata changed outside a setup cycle");

	property p_idle_after_reset;
		$rose(reset_n) |-> !core_active && !pready;
	endproperty
	a_idle_after_reset: assert property (p_idle_after_reset) else $error("outputs busy after reset");

	c_write: cover property (pready && pwrite && !pslverr);
	c_read_err: cover property (pready && !pwrite && pslverr);
	c_run: cover property ($rose(core_active));
	c_halt: cover property ($fell(core_active));
endmodule

bind mie_core mie_core_props u_props (
	.mclk        (mclk),
	.reset_n     (reset_n),
	.ce          (ce),
	.psel        (psel),
	.penable     (penable),
	.pwrite      (pwrite),
	.paddr       (paddr),
	.pwdata      (pwdata),
	.prdata      (prdata),
	.pready      (pready),
	.pslverr     (pslverr),
	.core_active (core_active)
);

//--- verification/mie_core_tb_top.sv
// Self-checking testbench of the execution core
`timescale 1ns/100ps
`include "mie_defines.svh"

module mie_core_tb_top;
	import mie_pkg::*;

	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        core_active;
	int          n_mismatch = 0;
	int          check_count = 0;
	logic [15:0] prog[$];
	logic [31:0] rd;
	logic [31:0] base;
	logic [31:0] cyc;
	logic        err;
	logic [15:0] hw;
	logic [31:0] act_clks = 32'h0;
	logic [31:0] clks;
	int          stall = 0;

	mie_core uut (
		.mclk        (mclk),
		.reset_n     (reset_n),
		.ce          (ce),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.core_active (core_active)
	);

	initial begin
		forever #20 mclk = ~mclk;
	end

	// Clocks during which the core reports itself active
	always @(posedge mclk) begin
		if (core_active === 1'b1) begin
			act_clks <= act_clks + 32'h1;
		end
	end

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Setup, access until pready, data taken in the pready cycle
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	task automatic dm_write(input logic [7:0] a, input logic [7:0] v);
		apb(1'b1, `MIE_OFS_DMEM_ADDR, {24'h0, a});
		apb(1'b1, `MIE_OFS_DMEM_DATA, {24'h0, v});
	endtask

	task automatic dm_chk(input logic [7:0] a, input logic [7:0] v);
		apb(1'b1, `MIE_OFS_DMEM_ADDR, {24'h0, a});
		apb(1'b0, `MIE_OFS_DMEM_DATA, 32'h0);
		chk(rd, {24'h0, v});
	endtask

	task automatic st_chk(input logic g, input logic c, input logic z, input logic [7:0] acc);
		apb(1'b0, `MIE_OFS_STATUS, 32'h0);
		chk(rd & 32'h000FFF00, {12'h0, 1'b1, g, c, z, acc, 8'h00});
	endtask

	// Loads prog, restarts, waits for halt; cyc gets instruction cycles, clks active clocks
	task automatic run_prog(input logic [31:0] ctrl);
		logic [31:0] t0;
		logic [31:0] a0;
		int i;
		a0 = act_clks;
		apb(1'b0, `MIE_OFS_ICOUNT, 32'h0);
		t0 = rd;
		apb(1'b1, `MIE_OFS_PROG_ADDR, 32'h0);
		foreach (prog[k]) begin
			apb(1'b1, `MIE_OFS_PROG_DATA, {16'h0, prog[k]});
		end
		apb(1'b1, `MIE_OFS_CTRL, ctrl);
		// Clock enable held low while the core runs and the bus is idle
		if (stall > 0) begin
			@(posedge mclk);
			ce <= 1'b0;
			repeat (stall) @(posedge mclk);
			ce <= 1'b1;
		end
		for (i = 0; i < 100; i++) begin
			apb(1'b0, `MIE_OFS_STATUS, 32'h0);
			if (rd[19] === 1'b1) begin
				break;
			end
		end
		if (i >= 100) begin
			n_mismatch++;
			give_verdict();
		end
		apb(1'b0, `MIE_OFS_ICOUNT, 32'h0);
		cyc = rd - t0;
		clks = act_clks - a0;
	endtask

	function automatic logic [15:0] ins(input mie_op_type op, input logic [2:0] s, input logic [7:0] a);
		return {op, s, a};
	endfunction

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		hw = ins(OP_HALT, 3'h0, 8'hA5);
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		apb(1'b0, `MIE_OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		dm_write(8'h08, 8'h81);
		dm_write(8'h09, 8'hFF);
		dm_write(8'h0B, 8'h5A);
		dm_write(8'h0C, 8'h01);
		prog = '{hw};
		run_prog(32'h5);
		base = cyc;
		prog = '{ins(OP_MOV_I2A, 3'h0, 8'hF0), ins(OP_ADD_I, 3'h0, 8'h20), hw};
		run_prog(32'h5);
		chk(cyc - base, 32'h2);
		st_chk(1'b0, 1'b1, 1'b0, 8'h10);
		prog = '{ins(OP_MOV_I2A, 3'h0, 8'h05), ins(OP_SUB_I, 3'h0, 8'h06), ins(OP_AND_I, 3'h0, 8'h00), hw};
		run_prog(32'h5);
		chk(cyc - base, 32'h3);
		chk(clks, 32'h14);
		st_chk(1'b0, 1'b1, 1'b1, 8'h00);
		prog = '{ins(OP_MOV_I2A, 3'h0, 8'h00), ins(OP_ADD_I, 3'h0, 8'h00), ins(OP_RLC, 3'h0, 8'h08),
			ins(OP_RRC, 3'h1, 8'h08), ins(OP_RL, 3'h0, 8'h08), hw};
		run_prog(32'h5);
		st_chk(1'b0, 1'b1, 1'b1, 8'h81);
		dm_chk(8'h08, 8'hC0);
		prog = '{ins(OP_INC, 3'h1, 8'h09), ins(OP_DEC, 3'h0, 8'h09), ins(OP_MOV_A2M, 3'h0, 8'h0A),
			ins(OP_MOV_M2A, 3'h0, 8'h09), hw};
		run_prog(32'h5);
		st_chk(1'b0, 1'b1, 1'b0, 8'h00);
		dm_chk(8'h09, 8'h00);
		dm_chk(8'h0A, 8'hFF);
		prog = '{ins(OP_BIT_SET, 3'h0, 8'h0B), ins(OP_BIT_CLEAR, 3'h6, 8'h0B), hw};
		run_prog(32'h5);
		chk(cyc - base, 32'h2);
		dm_chk(8'h0B, 8'h1B);
		prog = '{ins(OP_CALL, 3'h0, 8'h04), ins(OP_SKIP_BIT1, 3'h0, 8'h0B), ins(OP_MOV_I2A, 3'h0, 8'hEE), hw,
			ins(OP_MOV_I2A, 3'h0, 8'h33), ins(OP_RETURN, 3'h0, 8'h00)};
		run_prog(32'h7);
		chk(cyc - base, 32'h7);
		st_chk(1'b1, 1'b1, 1'b0, 8'h33);
		prog = '{ins(OP_JUMP, 3'h0, 8'h02), hw, ins(OP_SKIP_Z, 3'h0, 8'h0B), ins(OP_MOV_I2A, 3'h0, 8'h06),
			ins(OP_MOV_A2M, 3'h0, `MIE_ADDR_PCL), hw, ins(OP_CALL, 3'h0, 8'h08), hw,
			ins(OP_IRETURN, 3'h0, 8'h00)};
		run_prog(32'h5);
		chk(cyc - base, 32'hA);
		st_chk(1'b1, 1'b1, 1'b0, 8'h06);
		prog = '{ins(OP_TABRD, 3'h0, 8'h0C), hw};
		run_prog(32'h5);
		chk(cyc - base, 32'h2);
		st_chk(1'b0, 1'b1, 1'b0, 8'hA5);
		prog = '{ins(OP_MOV_I2A, 3'h0, 8'h3C), ins(OP_ADD_M, 3'h0, 8'h0B), ins(OP_SUB_M, 3'h0, 8'h0A),
			ins(OP_XOR_M, 3'h0, 8'h0A), ins(OP_RR, 3'h1, 8'h0B), ins(OP_CPL, 3'h0, 8'h0B),
			ins(OP_SKIP_BIT0, 3'h1, 8'h0B), ins(OP_MOV_I2A, 3'h0, 8'hEE), ins(OP_SKIP_BIT0, 3'h0, 8'h0B),
			ins(OP_OR_I, 3'h0, 8'h01), ins(OP_CALL, 3'h0, 8'h0C), hw, ins(OP_RETURN, 3'h0, 8'h00)};
		stall = 5;
		run_prog(32'h5);
		chk(cyc - base, 32'hE);
		chk(clks, 32'h45);
		st_chk(1'b0, 1'b1, 1'b0, 8'h73);
		dm_chk(8'h0B, 8'h8D);
		give_verdict();
	end
endmodule
